// *** rtl/dprf_pkg.sv ***
// Shared constants and helpers for the dual-port RAM with embedded FIFO controller
package dprf_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W    = 12;     // Port address width, upper index 11
   localparam int PTR_W     = 13;     // FIFO pointer: address plus wrap bit
   localparam int DATA_W    = 36;     // Widest port word
   localparam int MEM_BITS  = 4608;   // Storage bits of one block
   localparam int BUF_DEPTH = 8;      // Words in the write-side staging buffer

   // ----------------------------------------------------------------
   // Word width selector codes
   // ----------------------------------------------------------------
   localparam logic [2:0] WCODE_1  = 3'h0;
   localparam logic [2:0] WCODE_2  = 3'h1;
   localparam logic [2:0] WCODE_4  = 3'h2;
   localparam logic [2:0] WCODE_9  = 3'h3;
   localparam logic [2:0] WCODE_18 = 3'h4;
   localparam logic [2:0] WCODE_36 = 3'h5;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [PTR_W-1:0]  PTR_RST   = 13'h0000;
   localparam logic              EMPTY_RST = 1'b1;
   localparam logic              FULL_RST  = 1'b0;
   localparam logic [DATA_W-1:0] DATA_RST  = 36'h0_0000_0000;
   localparam logic [3:0]        CNT_RST   = 4'h0;

   // Bits per word for a selector code; unused codes fall back to one bit
   function automatic logic [5:0] width_bits(input logic [2:0] code);
      case (code)
         WCODE_2:  width_bits = 6'h02;
         WCODE_4:  width_bits = 6'h04;
         WCODE_9:  width_bits = 6'h09;
         WCODE_18: width_bits = 6'h12;
         WCODE_36: width_bits = 6'h24;
         default:  width_bits = 6'h01;
      endcase
   endfunction

   // Words per block for a selector code, always a power of two
   function automatic logic [PTR_W-1:0] depth_of(input logic [2:0] code);
      case (code)
         WCODE_2:  depth_of = 13'h0800;
         WCODE_4:  depth_of = 13'h0400;
         WCODE_9:  depth_of = 13'h0200;
         WCODE_18: depth_of = 13'h0100;
         WCODE_36: depth_of = 13'h0080;
         default:  depth_of = 13'h1000;
      endcase
   endfunction

   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = g;
      for (int i = PTR_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      gray2bin = b;
   endfunction

endpackage

// *** rtl/dprf_buf.sv ***
// Staging FIFO with valid/ready on both sides, flip-flop storage
`timescale 1ns/1ps
module dprf_buf
   import dprf_pkg::*;
#(
   parameter int W     = 49,
   parameter int DEPTH = BUF_DEPTH
) (
   // Clock, reset, enable
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int IW = $clog2(DEPTH);

   logic [W-1:0]  store_reg [DEPTH];
   logic [IW-1:0] wr_idx_reg;
   logic [IW-1:0] rd_idx_reg;
   logic [IW:0]   count_reg;
   logic          push;
   logic          pop;

   // Handshakes; out_ready is the drain's stall, so the buffer really fills
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_valid & out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data  = store_reg[rd_idx_reg];

   // ----------------------------------------------------------------
   // Storage, one word per entry
   // ----------------------------------------------------------------
   for (genvar e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge clk) begin
         if (push && wr_idx_reg == IW'(e)) begin
            store_reg[e] <= in_data;
         end
      end
   end

   // Indices and occupancy; ready is registered from the next count
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         count_reg  <= '0;
         in_ready   <= 1'b1;
      end else if (ce) begin
         if (push) begin
            wr_idx_reg <= IW'(wr_idx_reg + 1'b1);
         end
         if (pop) begin
            rd_idx_reg <= IW'(rd_idx_reg + 1'b1);
         end
         count_reg <= (IW+1)'(count_reg + {{IW{1'b0}}, push} - {{IW{1'b0}}, pop});
         in_ready  <= ((IW+1)'(count_reg + {{IW{1'b0}}, push} - {{IW{1'b0}}, pop}) != (IW+1)'(DEPTH));
      end
   end

endmodule // dprf_buf

// *** rtl/dprf_core.sv ***
// Dual-port RAM block with embedded Gray-pointer FIFO controller
`timescale 1ns/1ps

// What this block does
// - Write and read ports each pick rising or falling active edge.
// - Write address upper index lies between 6 and 11.
// - Read address upper index lies between 6 and 11.
// - Port words are 1, 2, 4, 9, 18 or 36 bits wide.
// - Read enable at active read edge drives addressed word onto read data.
// - Write enable high at active write edge stores the word at write address.
// - Non-pipelined: address registered, data out one cycle later.
// - Pipelined: data registered again, out after second read edge.
// - Little-endian ordering: lower addresses occupy lower bits.
// - One FIFO controller per block, one write and one read port.
// - Both FIFO ports synchronous, sized 4k x 1 up to 128 x 36.
// - FIFO pointers are Gray-coded before crossing between port domains.
// - Overflow and underflow blocked; flags come from flip-flops.
// - Each enabled write edge pushes the write word as next entry.
// - Each enabled read edge pops the oldest entry onto read data.
// - Write and read sides run independently, even on unrelated edges.
// - Empty, full and threshold-driven almost-empty, almost-full flags.
// - Full flag lives in write domain; writes wait in the 8-word staging buffer while full.
// - Empty flag lives in read domain; reads ignored while empty.
// - Reset empties the FIFO: pointers cleared, empty flag set.
module dprf_core
   import dprf_pkg::*;
#(
   parameter bit WR_FALL_EDGE = 1'b0,
   parameter bit RD_FALL_EDGE = 1'b0
) (
   // Clock, reset, enable
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Static configuration
   input  wire logic              fifo_mode,
   input  wire logic              pipe_on,
   input  wire logic [2:0]        write_word_width,
   input  wire logic [2:0]        read_word_width,
   input  wire logic [PTR_W-1:0]  ae_thresh,
   input  wire logic [PTR_W-1:0]  af_thresh,
   // Write port
   input  wire logic              write_en,
   input  wire logic [ADDR_W-1:0] write_addr,
   input  wire logic [DATA_W-1:0] write_data_in,
   output logic                   write_ready,
   // Read port
   input  wire logic              read_en,
   input  wire logic [ADDR_W-1:0] read_addr,
   output logic [DATA_W-1:0]      read_data,
   output logic                   read_valid,
   // FIFO flags
   output logic                   empty_flag,
   output logic                   full_flag,
   output logic                   almost_drained_flag,
   output logic                   almost_filled_flag
);

   // ----------------------------------------------------------------
   // Port clocks
   // ----------------------------------------------------------------
   // Inverting a port's clock gives falling-edge action
   logic wr_clk;
   logic rd_clk;
   assign wr_clk = sys_clk ^ WR_FALL_EDGE;
   assign rd_clk = sys_clk ^ RD_FALL_EDGE;

   logic                  mem_reg [MEM_BITS];
   logic [5:0]            wr_w;
   logic [5:0]            rd_w;
   logic [PTR_W-1:0]      wr_depth;
   logic [PTR_W-1:0]      rd_depth;
   assign wr_w     = width_bits(write_word_width);
   assign rd_w     = width_bits(read_word_width);
   assign wr_depth = depth_of(write_word_width);
   assign rd_depth = depth_of(read_word_width);

   // ----------------------------------------------------------------
   // Write side
   // ----------------------------------------------------------------
   logic [ADDR_W+DATA_W:0] buf_in;
   logic [ADDR_W+DATA_W:0] buf_out;
   logic                   buf_valid;
   logic                   drain_ok;
   logic                   wr_take;
   logic [ADDR_W-1:0]      wr_word;
   logic [18:0]            wr_prod;
   logic [12:0]            wr_off;
   logic [PTR_W-1:0]       wptr_bin_reg;
   logic [PTR_W-1:0]       wptr_gray_reg;
   logic [PTR_W-1:0]       wptr_next;
   logic [PTR_W-1:0]       rgray_s1_reg;
   logic [PTR_W-1:0]       rgray_s2_reg;
   logic [PTR_W-1:0]       fill_w_next;
   logic [PTR_W-1:0]       rptr_gray_reg;

   // Staging buffer absorbs bursts while the FIFO is full
   assign buf_in = {1'b0, write_addr, write_data_in};
   dprf_buf #(
      .W     (ADDR_W + DATA_W + 1),
      .DEPTH (BUF_DEPTH)
   ) u_wbuf (
      .clk       (wr_clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (write_en),
      .in_ready  (write_ready),
      .in_data   (buf_in),
      .out_valid (buf_valid),
      .out_ready (drain_ok),
      .out_data  (buf_out)
   );

   // A full FIFO stalls the drain, so no write lands while full
   assign drain_ok  = ~fifo_mode | ~full_flag;
   assign wr_take   = ce & buf_valid & drain_ok;
   assign wptr_next = PTR_W'(wptr_bin_reg + {12'h000, wr_take & fifo_mode});
   // FIFO mode takes its address from the write pointer
   assign wr_word   = (fifo_mode ? wptr_bin_reg[ADDR_W-1:0] : buf_out[ADDR_W+DATA_W-1:DATA_W])
                      & wr_depth[ADDR_W-1:0] - 12'h001;
   assign wr_prod   = {7'h00, wr_word} * {13'h0000, wr_w};
   assign wr_off    = wr_prod[12:0];

   // Memory write, word bit i at bit (addr*width + i): little-endian
   always_ff @(posedge wr_clk) begin
      if (wr_take) begin
         for (int i = 0; i < DATA_W; i++) begin
            if (i < int'(wr_w) && int'(wr_off) + i < MEM_BITS) begin
               mem_reg[int'(wr_off) + i] <= buf_out[i];
            end
         end
      end
   end

   // Two-flop synchroniser for the read pointer, Gray-coded
   always_ff @(posedge wr_clk) begin
      if (rst) begin
         rgray_s1_reg <= PTR_RST;
         rgray_s2_reg <= PTR_RST;
      end else if (ce) begin
         rgray_s1_reg <= rptr_gray_reg;
         rgray_s2_reg <= rgray_s1_reg;
      end
   end

   // Level seen from the write side is pessimistic, so overflow cannot occur
   assign fill_w_next = PTR_W'(wptr_next - gray2bin(rgray_s2_reg));

   // Write pointer and write-domain flags
   always_ff @(posedge wr_clk) begin
      if (rst) begin
         wptr_bin_reg       <= PTR_RST;
         wptr_gray_reg      <= PTR_RST;
         full_flag          <= FULL_RST;
         almost_filled_flag <= 1'b0;
      end else if (ce) begin
         wptr_bin_reg       <= wptr_next;
         wptr_gray_reg      <= bin2gray(wptr_next);
         full_flag          <= fifo_mode & (fill_w_next >= wr_depth);
         almost_filled_flag <= fifo_mode & (fill_w_next >= af_thresh);
      end
   end

   // ----------------------------------------------------------------
   // Read side
   // ----------------------------------------------------------------
   logic [PTR_W-1:0]  rptr_bin_reg;
   logic [PTR_W-1:0]  rptr_next;
   logic [PTR_W-1:0]  wgray_s1_reg;
   logic [PTR_W-1:0]  wgray_s2_reg;
   logic [PTR_W-1:0]  fill_r_next;
   logic              rd_take;
   logic [ADDR_W-1:0] rd_word;
   logic [18:0]       rd_prod;
   logic [12:0]       rd_off;
   logic [DATA_W-1:0] rd_word_bits;
   logic [DATA_W-1:0] stage_reg;
   logic              stage_valid_reg;

   // Reads while empty are ignored in FIFO mode
   assign rd_take   = ce & read_en & (~fifo_mode | ~empty_flag);
   assign rptr_next = PTR_W'(rptr_bin_reg + {12'h000, rd_take & fifo_mode});
   assign rd_word   = (fifo_mode ? rptr_bin_reg[ADDR_W-1:0] : read_addr) & rd_depth[ADDR_W-1:0] - 12'h001;
   assign rd_prod   = {7'h00, rd_word} * {13'h0000, rd_w};
   assign rd_off    = rd_prod[12:0];

   // Gather the addressed word, narrow words zero-extended
   always_comb begin
      rd_word_bits = '0;
      for (int i = 0; i < DATA_W; i++) begin
         if (i < int'(rd_w) && int'(rd_off) + i < MEM_BITS) begin
            rd_word_bits[i] = mem_reg[int'(rd_off) + i];
         end
      end
   end

   // Two-flop synchroniser for the write pointer
   always_ff @(posedge rd_clk) begin
      if (rst) begin
         wgray_s1_reg <= PTR_RST;
         wgray_s2_reg <= PTR_RST;
      end else if (ce) begin
         wgray_s1_reg <= wptr_gray_reg;
         wgray_s2_reg <= wgray_s1_reg;
      end
   end

   assign fill_r_next = PTR_W'(gray2bin(wgray_s2_reg) - rptr_next);

   // Read pointer and read-domain flags
   always_ff @(posedge rd_clk) begin
      if (rst) begin
         rptr_bin_reg        <= PTR_RST;
         rptr_gray_reg       <= PTR_RST;
         empty_flag          <= EMPTY_RST;
         almost_drained_flag <= 1'b1;
      end else if (ce) begin
         rptr_bin_reg        <= rptr_next;
         rptr_gray_reg       <= bin2gray(rptr_next);
         empty_flag          <= ~fifo_mode | (fill_r_next == '0);
         almost_drained_flag <= ~fifo_mode | (fill_r_next <= ae_thresh);
      end
   end

   // Output registers: one edge without pipe, two with pipe
   always_ff @(posedge rd_clk) begin
      if (rst) begin
         stage_reg       <= DATA_RST;
         stage_valid_reg <= 1'b0;
         read_data       <= DATA_RST;
         read_valid      <= 1'b0;
      end else if (ce) begin
         stage_valid_reg <= rd_take & pipe_on;
         if (rd_take) begin
            stage_reg <= rd_word_bits;
         end
         if (pipe_on) begin
            read_valid <= stage_valid_reg;
            if (stage_valid_reg) begin
               read_data <= stage_reg;
            end
         end else begin
            read_valid <= rd_take;
            if (rd_take) begin
               read_data <= rd_word_bits;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_take_pipe;
      ce && rd_take && pipe_on;
   endsequence
   sequence s_stage_then_out;
      ce && stage_valid_reg ##1 read_valid;
   endsequence

   full_blocks_a: assert property (@(posedge wr_clk) disable iff (rst)
      (ce && fifo_mode && full_flag) |=> (wptr_bin_reg == $past(wptr_bin_reg)))
      else $error("write pointer moved while full");

   empty_blocks_a: assert property (@(posedge rd_clk) disable iff (rst)
      (ce && fifo_mode && empty_flag) |=> (rptr_bin_reg == $past(rptr_bin_reg)) && !stage_valid_reg
         && (pipe_on || !read_valid))
      else $error("read taken while empty");

   reset_empty_a: assert property (@(posedge rd_clk)
      rst |=> (empty_flag && rptr_bin_reg == PTR_RST && !read_valid))
      else $error("reset did not empty the fifo");

   wgray_step_a: assert property (@(posedge wr_clk) disable iff (rst)
      $onehot0(wptr_gray_reg ^ $past(wptr_gray_reg)))
      else $error("write gray pointer changed more than one bit");

   rgray_step_a: assert property (@(posedge rd_clk) disable iff (rst)
      $onehot0(rptr_gray_reg ^ $past(rptr_gray_reg)))
      else $error("read gray pointer changed more than one bit");

   nopipe_latency_a: assert property (@(posedge rd_clk) disable iff (rst)
      (rd_take && !pipe_on) |=> (read_valid && read_data == $past(rd_word_bits)))
      else $error("non-pipelined read not out after one edge");

   pipe_latency_a: assert property (@(posedge rd_clk) disable iff (rst)
      s_take_pipe |=> s_stage_then_out)
      else $error("pipelined read not out after two edges");

   push_step_a: assert property (@(posedge wr_clk) disable iff (rst)
      (wr_take && fifo_mode) |=> (wptr_bin_reg == PTR_W'($past(wptr_bin_reg) + 13'h0001)))
      else $error("accepted write did not advance pointer");

   fill_bound_a: assert property (@(posedge wr_clk) disable iff (rst)
      fifo_mode |-> (PTR_W'(wptr_bin_reg - gray2bin(rgray_s2_reg)) <= wr_depth))
      else $error("fifo level beyond depth");

   full_almost_a: assert property (@(posedge wr_clk) disable iff (rst)
      (full_flag && af_thresh <= wr_depth) |-> almost_filled_flag)
      else $error("full without almost-full");

endmodule // dprf_core

// *** test/dprf_user.sv ***
// Partner model: user logic that drives the write and read ports
`timescale 1ns/1ps
module dprf_user
   import dprf_pkg::*;
(
   // Clock and back-pressure
   input  wire logic          sys_clk,
   input  wire logic          write_ready,
   // Write request
   output logic               write_en,
   output logic [ADDR_W-1:0]  write_addr,
   output logic [DATA_W-1:0]  write_data_in,
   // Read request
   output logic               read_en,
   output logic [ADDR_W-1:0]  read_addr
);
   // Idle at time zero
   initial begin
      write_en = 1'b0;
      write_addr = '0;
      write_data_in = '0;
      read_en = 1'b0;
      read_addr = '0;
   end

   // Request stands until an edge samples ready high
   task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      write_en      <= 1'b1;
      write_addr    <= a;
      write_data_in <= d;
      for (int i = 0; i < 600; i++) begin
         @(posedge sys_clk);
         if (write_ready) break;
      end
   endtask

   // Keeps asking while refused, to prove nothing sneaks in
   task automatic write_hold(input int n);
      write_en <= 1'b1;
      repeat (n) @(posedge sys_clk);
   endtask

   // Released lines flip, so a stale copy never looks valid
   task automatic write_idle();
      write_en      <= 1'b0;
      write_addr    <= ~write_addr;
      write_data_in <= ~write_data_in;
   endtask

   // One read per edge, back to back allowed
   task automatic read_word(input logic [ADDR_W-1:0] a);
      read_en   <= 1'b1;
      read_addr <= a;
      @(posedge sys_clk);
   endtask

   task automatic read_idle();
      read_en   <= 1'b0;
      read_addr <= ~read_addr;
   endtask
endmodule // dprf_user

// *** test/test_dual_port_ram_with_fifo.sv ***
// Self-checking bench for the RAM block with embedded FIFO controller
`timescale 1ns/1ps
module test_dual_port_ram_with_fifo
   import dprf_pkg::*;
;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   logic              fifo_mode = 1'b0;
   logic              pipe_on = 1'b0;
   logic [2:0]        wcode = 3'h0;
   logic [2:0]        rcode = 3'h0;
   logic [PTR_W-1:0]  ae_thr = 13'h0005;
   logic [PTR_W-1:0]  af_thr = 13'h0000;
   logic              write_en, read_en, write_ready, read_valid;
   logic              empty_flag, full_flag, ae_f, af_f;
   logic [ADDR_W-1:0] write_addr, read_addr;
   logic [DATA_W-1:0] write_data_in, read_data;
   logic              mem_m [0:MEM_BITS-1];
   logic [DATA_W-1:0] exq [$];
   logic [1:0]        sh = 2'h0;
   int                n_errors = 0;
   int                n_tests = 0;
   int                n_wr = 0;
   int                cyc = 0;
   int                seed;
   int                WID [6] = '{1, 2, 4, 9, 18, 36};
   int                DEP [6] = '{4096, 2048, 1024, 512, 256, 128};

   dprf_core dprf_core_inst (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .fifo_mode(fifo_mode), .pipe_on(pipe_on),
      .write_word_width(wcode), .read_word_width(rcode), .ae_thresh(ae_thr), .af_thresh(af_thr),
      .write_en(write_en), .write_addr(write_addr), .write_data_in(write_data_in), .write_ready(write_ready),
      .read_en(read_en), .read_addr(read_addr), .read_data(read_data), .read_valid(read_valid),
      .empty_flag(empty_flag), .full_flag(full_flag), .almost_drained_flag(ae_f), .almost_filled_flag(af_f));

   dprf_user dprf_user_inst (.sys_clk(sys_clk), .write_ready(write_ready), .write_en(write_en),
      .write_addr(write_addr), .write_data_in(write_data_in), .read_en(read_en), .read_addr(read_addr));

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Low bits of a word at the given width; design zero-fills the rest
   function automatic logic [DATA_W-1:0] msk(input logic [2:0] c);
      logic [36:0] m;
      m = (37'h1 << WID[c]) - 37'h1;
      return m[35:0];
   endfunction

   // Little-endian bit space: word bit i sits at addr*width+i
   function automatic logic [DATA_W-1:0] ram_rd(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] v;
      v = '0;
      for (int i = 0; i < WID[rcode]; i++) v[i] = mem_m[int'(a) * WID[rcode] + i];
      return v;
   endfunction

   // Scoreboard; sees the values each edge samples, so no race with the drivers
   always @(posedge sys_clk) begin
      if (rst) begin
         sh = 2'h0;
         n_wr = 0;
         exq.delete();
      end else begin
         check("read_valid", read_valid, pipe_on ? sh[1] : sh[0]);
         if (read_valid === 1'b1) begin
            if (exq.size() == 0) check("spare word", 1'b1, 1'b0);
            else check("read_data", read_data, exq.pop_front());
         end
         sh = {sh[0], read_en && (!fifo_mode || !empty_flag)};
         if (read_en && !fifo_mode) exq.push_back(ram_rd(read_addr));
         if (write_en && write_ready) begin
            n_wr++;
            if (fifo_mode) exq.push_back(write_data_in & msk(wcode));
            else for (int i = 0; i < WID[wcode]; i++) mem_m[int'(write_addr) * WID[wcode] + i] = write_data_in[i];
         end
      end
   end

   // Hang guard, well above the roughly 19k cycles the run needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   // Static setup changes only under reset, four edges long
   task automatic setup(input logic fm, input logic p, input logic [2:0] wc, input logic [2:0] rc);
      @(posedge sys_clk);
      fifo_mode <= fm;
      pipe_on   <= p;
      wcode     <= wc;
      rcode     <= rc;
      af_thr    <= PTR_W'(DEP[wc] - 4);
      rst       <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic read_n(input int n);
      for (int i = 0; i < n; i++) dprf_user_inst.read_word(ADDR_W'($urandom));
      dprf_user_inst.read_idle();
      repeat (10) @(posedge sys_clk);
   endtask

   initial begin
      seed = $urandom(47);
      // RAM mode: 576 bits filled at one width, read back at a randomly chosen width
      for (int it = 0; it < 8; it++) begin
         setup(1'b0, 1'($urandom % 2), it < 6 ? 3'(it) : 3'($urandom % 6), 3'($urandom % 6));
         for (int i = 0; i < 576 / WID[wcode]; i++)
            dprf_user_inst.write_word(ADDR_W'(i), DATA_W'({$urandom(), $urandom()}));
         dprf_user_inst.write_idle();
         repeat (12) @(posedge sys_clk);
         for (int i = 0; i < 17; i++)
            dprf_user_inst.read_word(ADDR_W'(i == 16 ? 576 / WID[rcode] - 1 : $urandom % (576 / WID[rcode])));
         read_n(0);
      end
      // FIFO at every width: fill past full, then drain across both thresholds
      for (int c = 5; c >= 0; c--) begin
         setup(1'b1, 1'($urandom % 2), 3'(c), 3'(c));
         for (int i = 0; i < DEP[c] + 8; i++) dprf_user_inst.write_word('0, DATA_W'({$urandom(), $urandom()}));
         dprf_user_inst.write_hold(10);
         dprf_user_inst.write_idle();
         repeat (10) @(posedge sys_clk);
         check("full_flag", full_flag, 1'b1);
         check("write_ready", write_ready, 1'b0);
         check("almost_filled", af_f, 1'b1);
         check("words taken", n_wr, DEP[c] + 8);
         read_n(13);
         check("almost_filled", af_f, 1'b0);
         check("full_flag", full_flag, 1'b0);
         read_n(DEP[c] - 11);
         check("almost_drained", ae_f, 1'b0);
         read_n(1);
         check("almost_drained", ae_f, 1'b1);
         check("empty_flag", empty_flag, 1'b0);
         read_n(5);
         check("empty_flag", empty_flag, 1'b1);
         read_n(4);
      end
      // Reset in mid-fill must empty the FIFO
      setup(1'b1, 1'b0, 3'h5, 3'h5);
      for (int i = 0; i < 20; i++) dprf_user_inst.write_word('0, DATA_W'($urandom));
      dprf_user_inst.write_idle();
      repeat (10) @(posedge sys_clk);
      check("empty_flag", empty_flag, 1'b0);
      setup(1'b1, 1'b1, 3'h5, 3'h5);
      check("empty_flag", empty_flag, 1'b1);
      check("full_flag", full_flag, 1'b0);
      check("write_ready", write_ready, 1'b1);
      check("almost_drained", ae_f, 1'b1);
      check("read_data", read_data, '0);
      read_n(3);
      // Both sides stalling at random and running at once
      setup(1'b1, 1'($urandom % 2), 3'h4, 3'h4);
      fork
         for (int i = 0; i < 60; i++) begin
            dprf_user_inst.write_word('0, DATA_W'({$urandom(), $urandom()}));
            if (i == 59 || $urandom % 3 == 0) begin
               dprf_user_inst.write_idle();
               @(posedge sys_clk);
            end
         end
         for (int i = 0; i < 60; i++) begin
            dprf_user_inst.read_word('0);
            if ($urandom % 2 == 0) begin
               dprf_user_inst.read_idle();
               @(posedge sys_clk);
            end
         end
      join
      dprf_user_inst.write_idle();
      read_n(0);
      read_n(80);
      check("words left", exq.size(), 0);
      wrap_up();
   end
endmodule // test_dual_port_ram_with_fifo
